// File: core/spi_frame_defs.svh
// register offsets, field positions and constants of the spi frame format block
`ifndef SPI_FRAME_DEFS_SVH
`define SPI_FRAME_DEFS_SVH
`define ADDR_W           6
`define OFF_COUNTS       6'h08
`define OFF_FORMAT       6'h0c
`define OFF_CONTROL      6'h00
`define OFF_CLOCK        6'h14
`define OFF_STATUS       6'h18
`define CTL_ENABLE       0
`define CTL_CONTROLLER   1
`define CTL_START        5
`define FMT_POL_LO       16
`define FMT_THREE_WIRE   15
`define FMT_WIDTH_LO     12
`define FMT_BITS_LO      8
`define FMT_CPOL         1
`define FMT_CPHA         0
`define FMT_WMASK        32'h000fbf03
`define CLK_SCALE_LO     16
`define CLK_SCALE_MAX    4'h8
`define CLK_WMASK        32'h000f0000
`define CTL_WMASK        32'h00000023
`define LANES_ONE        2'h0
`define LANES_DUAL       2'h1
`define LANES_QUAD       2'h2
`define BITS_FULL        5'h10
`endif

// File: core/spi_frame_pkg.sv
// types of the spi frame format block
package spi_frame_pkg;
    typedef enum logic [2:0]
    {
        st_idle = 3'b001,
        st_low  = 3'b010,
        st_high = 3'b100
    } phase_t;
    typedef enum logic [1:0]
    {
        lanes_one  = 2'h0,
        lanes_dual = 2'h1,
        lanes_quad = 2'h2
    } lanes_t;
endpackage

// File: core/spi_frame_format_control.sv
// spi port with frame format control registers and serial engine
// How it works
// - counts word high half: receive characters
// - counts word low half: transmit characters
// - four-wire uses transmit count both ways
// - polarity bit n governs select line n
// - polarity 0 active low, 1 high
// - bit 15: 0 four-wire, 1 three-wire
// - three-wire bit ignored in dual mode
// - lane width 0/1/2 = 1/2/4 lanes, 3 reserved
// - three-wire: half duplex on lane 0
// - four-wire: out lane 0, in miso
// - dual: half duplex on lanes 0,1
// - quad: half duplex on lanes 0-3
// - character length 1..15, 0 means 16
// - controller select drives clock and selects
// - serial clock is input over 2^(scale+1), scale 0..8
//
// Local design decision: the strobed register port.
`include "spi_frame_defs.svh"
module spi_frame_format_control
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // register port
    input  wire logic [5:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // transmit character source
    input  wire logic [15:0] i_tx_char,
    output logic             o_tx_take,
    // received characters
    output logic      [15:0] o_rx_char,
    output logic             o_rx_valid,
    // serial pins
    output logic             o_sclk,
    output logic      [3:0]  o_target_select,
    input  wire logic [3:0]  i_data_lane,
    output logic      [3:0]  o_data_lane,
    output logic      [3:0]  o_data_lane_oe,
    input  wire logic        i_miso
);
    import spi_frame_pkg::*;

    typedef struct packed
    {
        logic [31:0] counts;
        logic [31:0] format;
        logic [31:0] control;
        logic [31:0] clock;
        logic [31:0] rdata;
        logic [4:0]  pin_s1;
        logic [4:0]  pin_s2;
        phase_t      phase;
        logic        sending;
        logic [15:0] chars_left;
        logic [4:0]  bits_left;
        logic [8:0]  div;
        logic [15:0] shift_out;
        logic [15:0] shift_in;
        logic        tx_take;
        logic [15:0] rx_char;
        logic        rx_valid;
        logic        sclk;
        logic [3:0]  sel;
        logic [3:0]  lane_out;
        logic [3:0]  lane_oe;
        logic        done;
    } state_t;

    state_t st;
    state_t next_st;

    function automatic logic [4:0] char_bits(input logic [3:0] code);
        char_bits = (code == 4'h0) ? `BITS_FULL : {1'b0, code};
    endfunction

    function automatic logic [2:0] lane_step(input logic [1:0] w);
        unique case (w)
            `LANES_DUAL: lane_step = 3'h2;
            `LANES_QUAD: lane_step = 3'h4;
            default:     lane_step = 3'h1;
        endcase
    endfunction

    logic [1:0]  width;
    logic        three;
    logic        half;
    logic [2:0]  step;
    logic [8:0]  half_period;
    logic [3:0]  scale;
    logic        rx_only;
    logic [15:0] in_next;

    always_comb
    begin
        width       = st.format[`FMT_WIDTH_LO +: 2];
        three       = st.format[`FMT_THREE_WIRE] && width == `LANES_ONE;
        half        = three || width != `LANES_ONE;
        step        = lane_step(width);
        scale       = (st.clock[`CLK_SCALE_LO +: 4] > `CLK_SCALE_MAX) ? `CLK_SCALE_MAX
                      : st.clock[`CLK_SCALE_LO +: 4];
        half_period = 9'h1 << scale;
        rx_only     = half && !st.sending;
        in_next     = st.shift_in;
        unique case (width)
            `LANES_DUAL: in_next = {st.shift_in[13:0], st.pin_s2[1:0]};
            `LANES_QUAD: in_next = {st.shift_in[11:0], st.pin_s2[3:0]};
            default:
            begin
                if (three)
                    in_next = {st.shift_in[14:0], st.pin_s2[0]};
                else
                    in_next = {st.shift_in[14:0], st.pin_s2[4]};
            end
        endcase

        next_st          = st;
        next_st.pin_s1   = {i_miso, i_data_lane};
        next_st.pin_s2   = st.pin_s1;
        next_st.tx_take  = 1'b0;
        next_st.rx_valid = 1'b0;
        next_st.rdata    = 32'h0;

        if (i_wr)
        begin
            unique case (i_addr)
                `OFF_COUNTS:  next_st.counts  = i_wdata;
                `OFF_FORMAT:  next_st.format  = i_wdata & `FMT_WMASK;
                `OFF_CONTROL: next_st.control = i_wdata & `CTL_WMASK;
                `OFF_CLOCK:   next_st.clock   = i_wdata & `CLK_WMASK;
                default:      next_st.done    = st.done;
            endcase
            if (i_addr == `OFF_STATUS && i_wdata[0])
                next_st.done = 1'b0;
        end
        if (i_rd)
        begin
            unique case (i_addr)
                `OFF_COUNTS:  next_st.rdata = st.counts;
                `OFF_FORMAT:  next_st.rdata = st.format;
                `OFF_CONTROL: next_st.rdata = st.control & ~(32'h1 << `CTL_START);
                `OFF_CLOCK:   next_st.rdata = st.clock;
                `OFF_STATUS:  next_st.rdata = {14'h0, st.chars_left, st.done, st.phase != st_idle};
                default:      next_st.rdata = 32'h0;
            endcase
        end

        unique case (st.phase)
            st_idle:
            begin
                next_st.sclk    = st.format[`FMT_CPOL];
                next_st.lane_oe = 4'h0;
                if (st.control[`CTL_START] && st.control[`CTL_ENABLE] && st.control[`CTL_CONTROLLER])
                begin
                    next_st.control[`CTL_START] = 1'b0;
                    next_st.sending = st.counts[15:0] != 16'h0;
                    if (!half || st.counts[15:0] != 16'h0)
                        next_st.chars_left = st.counts[15:0];
                    else
                        next_st.chars_left = st.counts[31:16];
                    if (next_st.chars_left != 16'h0)
                    begin
                        next_st.phase     = st_low;
                        next_st.bits_left = char_bits(st.format[`FMT_BITS_LO +: 4]);
                        next_st.shift_out = i_tx_char;
                        next_st.tx_take   = next_st.sending;
                        next_st.div       = half_period;
                    end
                end
            end
            st_low:
            begin
                next_st.lane_oe = rx_only ? 4'h0 : (three || half ? (4'hf >> (3'h4 - step)) : 4'h1);
                unique case (width)
                    `LANES_DUAL: next_st.lane_out = {2'h0, st.shift_out[15:14]};
                    `LANES_QUAD: next_st.lane_out = st.shift_out[15:12];
                    default:     next_st.lane_out = {3'h0, st.shift_out[15]};
                endcase
                next_st.div = st.div - 9'h1;
                if (st.div == 9'h1)
                begin
                    next_st.phase    = st_high;
                    next_st.div      = half_period;
                    next_st.sclk     = ~st.sclk;
                    next_st.shift_in = in_next;
                end
            end
            st_high:
            begin
                next_st.div = st.div - 9'h1;
                if (st.div == 9'h1)
                begin
                    next_st.sclk      = ~st.sclk;
                    next_st.div       = half_period;
                    next_st.shift_out = st.shift_out << step;
                    next_st.phase     = st_low;
                    if (st.bits_left <= {2'h0, step})
                    begin
                        next_st.rx_char    = st.shift_in & (16'hffff >> (5'h10 - char_bits(st.format[`FMT_BITS_LO +: 4])));
                        next_st.rx_valid   = !(half && st.sending);
                        next_st.chars_left = st.chars_left - 16'h1;
                        next_st.bits_left  = char_bits(st.format[`FMT_BITS_LO +: 4]);
                        next_st.shift_out  = i_tx_char;
                        next_st.tx_take    = st.sending && st.chars_left != 16'h1;
                        if (st.chars_left == 16'h1)
                        begin
                            if (half && st.sending && st.counts[31:16] != 16'h0)
                            begin
                                next_st.sending    = 1'b0;
                                next_st.chars_left = st.counts[31:16];
                            end
                            else
                            begin
                                // lanes released with the select, never after it
                                next_st.phase   = st_idle;
                                next_st.done    = 1'b1;
                                next_st.lane_oe = 4'h0;
                            end
                        end
                    end
                    else
                        next_st.bits_left = st.bits_left - {2'h0, step};
                end
            end
            default: next_st.phase = st_idle;
        endcase

        for (int i = 0; i < 4; i++)
        begin
            next_st.sel[i] = (next_st.phase != st_idle) ~^ st.format[`FMT_POL_LO + i];
            if (!st.control[`CTL_CONTROLLER])
                next_st.sel[i] = ~st.format[`FMT_POL_LO + i];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st       <= '0;
            st.phase <= st_idle;
            st.sel   <= 4'hf;
        end
        else
            st <= next_st;
    end

    assign o_rdata         = st.rdata;
    assign o_tx_take       = st.tx_take;
    assign o_rx_char       = st.rx_char;
    assign o_rx_valid      = st.rx_valid;
    assign o_sclk          = st.sclk;
    assign o_target_select = st.sel;
    assign o_data_lane     = st.lane_out;
    assign o_data_lane_oe  = st.lane_oe;
endmodule

// File: dv/spi_frame_format_control_sva.sv
// port assertions of the spi frame format block
`include "spi_frame_defs.svh"
module spi_frame_sva
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [5:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        o_sclk,
    input wire logic [3:0]  o_target_select,
    input wire logic [3:0]  o_data_lane_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt;
    logic [31:0] fmt;
    logic [3:0]  scale;
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            cnt   <= 32'h0;
            fmt   <= 32'h0;
            scale <= 4'h0;
        end
        else if (i_wr)
        begin
            if (i_addr == `OFF_COUNTS) cnt <= i_wdata;
            if (i_addr == `OFF_FORMAT) fmt <= i_wdata & `FMT_WMASK;
            if (i_addr == `OFF_CLOCK) scale <= i_wdata[19:16];
        end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_read(a);
        i_rd && i_addr == a;
    endsequence
    a_counts_read: assert property (s_read(`OFF_COUNTS) |=> o_rdata == $past(cnt))
        else $error("counts word read back wrong");
    a_format_read: assert property (s_read(`OFF_FORMAT) |=> o_rdata == $past(fmt))
        else $error("format word read back wrong");
    a_pol_idle: assert property (i_wr && i_addr == `OFF_FORMAT && o_data_lane_oe == 4'h0
        |=> ##1 o_target_select == ~fmt[19:16]) else $error("idle select level wrong");
    a_oe_select: assert property (o_data_lane_oe != 4'h0 |-> o_target_select[0] == fmt[16])
        else $error("lanes driven without select");
    a_one_lane: assert property (fmt[13:12] == 2'h0 && o_data_lane_oe != 4'h0 |-> o_data_lane_oe == 4'h1)
        else $error("single lane mode drives other lanes");
    a_dual_lanes: assert property (fmt[13:12] == 2'h1 |-> o_data_lane_oe[3:2] == 2'h0)
        else $error("dual mode drives upper lanes");
    a_quad_lanes: assert property (fmt[13:12] == 2'h2 && o_data_lane_oe != 4'h0 |-> o_data_lane_oe == 4'hf)
        else $error("quad mode lanes not all driven");
    a_sclk_half: assert property (scale == 4'h3 && $changed(o_sclk) |=> $stable(o_sclk)[*7])
        else $error("serial clock half period wrong");
endmodule

// File: dv/spi_target_model.sv
// behavioural spi target answering all ones while selected
module spi_target_model
(
    // pins seen from the port
    input  wire logic       i_clk,
    input  wire logic       i_sel,
    input  wire logic [3:0] i_lane,
    input  wire logic [3:0] i_lane_oe,
    // pins driven back
    output logic            o_miso,
    output logic      [3:0] o_lane
);
    timeunit 1ns;
    timeprecision 1ps;
    logic t = 1'b0;
    always @(posedge i_clk) t <= ~t;
    // deselected lines wander so stale data never looks valid
    assign o_miso = i_sel ? 1'b1 : t;
    for (genvar i = 0; i < 4; i++)
    begin : g_lane
        assign o_lane[i] = i_lane_oe[i] ? i_lane[i] : (i_sel ? 1'b1 : t);
    end
endmodule

// File: dv/spi_frame_format_control_test.sv
// self-checking bench of the spi frame format block
`include "spi_frame_defs.svh"
module spi_frame_format_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] e;} reg_row_t;
    typedef struct {logic [31:0] f; logic [31:0] c; int t; int r; logic [15:0] ch;} xfer_row_t;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [5:0]  i_addr = 6'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, d;
    logic [15:0] i_tx_char = 16'ha5c3, o_rx_char, last_rx;
    logic        o_tx_take, o_rx_valid, o_sclk, i_miso, sel;
    logic [3:0]  o_target_select, i_data_lane, o_data_lane, o_data_lane_oe, pol = 4'h0;
    int          bad_count = 0, samples_checked = 0, takes, rxs, n;
    reg_row_t    regs [5] = '{'{`OFF_COUNTS, 32'h1234abcd, 32'h1234abcd}, '{`OFF_FORMAT, 32'hffffffff, `FMT_WMASK},
                              '{`OFF_CLOCK, 32'hffffffff, `CLK_WMASK}, '{6'h10, 32'hffffffff, 32'h0},
                              '{`OFF_COUNTS, 32'h0, 32'h0}};
    // lengths 8 and 16 only, multiples of the lane count
    xfer_row_t   xfers [4] = '{'{32'h00000800, 32'h00050002, 2, 2, 16'h00ff}, '{32'h00008800, 32'h00020001, 1, 2, 16'h00ff},
                               '{32'h00019800, 32'h00010001, 1, 1, 16'h00ff}, '{32'h00002000, 32'h00010002, 2, 1, 16'hffff}};
    always #4 i_clk = ~i_clk;
    assign sel = o_target_select[0] == pol[0];
    spi_frame_format_control DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_char(i_tx_char), .o_tx_take(o_tx_take), .o_rx_char(o_rx_char),
        .o_rx_valid(o_rx_valid), .o_sclk(o_sclk), .o_target_select(o_target_select), .i_data_lane(i_data_lane),
        .o_data_lane(o_data_lane), .o_data_lane_oe(o_data_lane_oe), .i_miso(i_miso));
    spi_target_model far (.i_clk(i_clk), .i_sel(sel), .i_lane(o_data_lane), .i_lane_oe(o_data_lane_oe),
        .o_miso(i_miso), .o_lane(i_data_lane));
    always @(negedge i_clk)
    begin
        if (o_tx_take) takes++;
        if (o_rx_valid) rxs++;
        if (o_rx_valid) last_rx = o_rx_char;
    end
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [5:0] a, logic [31:0] v);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(logic [5:0] a, output logic [31:0] v);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
        @(posedge i_clk);
    endtask
    task automatic run(xfer_row_t r);
        wr(`OFF_COUNTS, r.c);
        wr(`OFF_FORMAT, r.f);
        pol = r.f[19:16];
        @(negedge i_clk);
        check("idle select", {28'h0, ~pol}, {28'h0, o_target_select});
        @(posedge i_clk);
        takes = 0;
        rxs = 0;
        wr(`OFF_CONTROL, 32'h23);
        for (n = 0; n < 20 && !sel; n++) @(posedge i_clk);
        for (n = 0; n < 3000 && sel; n++) @(posedge i_clk);
        check("select released", 32'h0, {31'h0, sel});
        repeat (20) @(posedge i_clk);
        check("takes", r.t, takes);
        check("receives", r.r, rxs);
        check("rx char", r.ch, last_rx);
        $display("transfer with format %h done", r.f);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        finish_test();
    end
    initial
    begin
        repeat (5) @(posedge i_clk);
        check("reset select", 32'hf, {28'h0, o_target_select});
        check("reset oe", 32'h0, {28'h0, o_data_lane_oe});
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd(`OFF_FORMAT, d);
        check("reset format", 32'h0, d);
        foreach (regs[i])
        begin
            wr(regs[i].a, regs[i].d);
            rd(regs[i].a, d);
            check("register", regs[i].e, d);
        end
        $display("register rows done");
        wr(`OFF_CLOCK, 32'h00030000);
        foreach (xfers[i]) run(xfers[i]);
        finish_test();
    end
endmodule
bind spi_frame_format_control spi_frame_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sclk(o_sclk),
    .o_target_select(o_target_select), .o_data_lane_oe(o_data_lane_oe));
